// ---- rtl/ivd_config_top.sv ----
/*
  Top of the input voltage detect configuration block: a serial two-wire
  target that takes a register pointer and data bytes, reads back with
  pointer auto-increment, and the register bank behind it.
  Assumes scl_i and sda_i are already synchronous to clk_i, that the
  host keeps each line level for several clk_i periods, and that the
  board resolves the open-drain data line from sda_oe_o.
*/
// Functional notes
// RQ1 - Bit 7 enables input protection, reset off
// RQ2 - Bit 6 selects regulation over protection
// RQ3 - Bit 5 enables supply detector, reset on
// RQ4 - Bits 4:0 hold falling level code
// RQ5 - Rising level code bits 4:0, reset 3
// RQ6 - Unimplemented bits always read back zero
// RQ7 - Writes to unimplemented bits are dropped
// RQ8 - Protection register reads 0x20 after reset
// RQ9 - Overvoltage register reads 0x3F after reset
// RQ10 - Six-bit second overvoltage level code
// RQ11 - Host writes registers by address over serial
`timescale 1ns/1ps
`default_nettype none

module ivd_config_top
  import ivd_pkg::*;
#(
  parameter int DEV_ADDR = 'h3A // Target address, free to change per board
)
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic input_protect_enable_o,
  output logic input_regulation_select_o,
  output logic supply_detector_enable_o,
  output logic [LEVEL_W-1:0] detector_fall_level_o,
  output logic [LEVEL_W-1:0] detector_rise_level_o,
  output logic [OVP2_W-1:0] second_overvoltage_level_o
);

  // Refuse addresses that do not fit seven bits
  if (DEV_ADDR < 0 || DEV_ADDR > 127)
  begin : g_bad_addr
    $error("DEV_ADDR must fit in seven bits");
  end

  localparam logic [6:0] OWN_ADDR = 7'(DEV_ADDR);

  ivd_state_t state_ff;
  ivd_state_t nxt_state;
  logic scl_q_ff;
  logic sda_q_ff;
  logic scl_d_ff;
  logic sda_d_ff;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic [7:0] tx_ff;
  logic [7:0] nxt_tx;
  logic drv_ff;
  logic nxt_drv;
  logic rd_ff;
  logic nxt_rd;
  logic nxt_oe;
  logic wr_en;
  logic [7:0] rd_data;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] rx_byte;

  // Line events from the sampled levels
  assign scl_rise = scl_q_ff & ~scl_d_ff;
  assign scl_fall = ~scl_q_ff & scl_d_ff;
  assign start_cond = scl_q_ff & scl_d_ff & sda_d_ff & ~sda_q_ff;
  assign stop_cond = scl_q_ff & scl_d_ff & ~sda_d_ff & sda_q_ff;
  assign rx_byte = {shift_ff[6:0], sda_q_ff};

  // Line samples; idle-high reset keeps a false start from firing
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else if (ce_i)
    begin
      scl_q_ff <= scl_i;
      sda_q_ff <= sda_i;
      scl_d_ff <= scl_q_ff;
      sda_d_ff <= sda_q_ff;
    end
  end

  // Target sequencing; start and stop override any state
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_ptr = ptr_ff;
    nxt_tx = tx_ff;
    nxt_drv = drv_ff;
    nxt_rd = rd_ff;
    nxt_oe = sda_oe_o;
    wr_en = 1'b0;
    if (start_cond)
    begin
      nxt_state = ST_ADDR;
      nxt_cnt = CNT_ZERO;
      nxt_drv = 1'b0;
      nxt_oe = 1'b0;
    end
    else if (stop_cond)
    begin
      nxt_state = ST_IDLE;
      nxt_drv = 1'b0;
      nxt_oe = 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_ADDR, ST_PTR, ST_WDATA:
        begin
          // Bytes arrive MSB first, sampled on the clock's rising edge
          if (scl_rise)
          begin
            nxt_shift = rx_byte;
            nxt_cnt = 4'(cnt_ff + CNT_ONE);
            if (cnt_ff == LAST_BIT)
            begin
              nxt_cnt = CNT_ZERO;
              if (state_ff == ST_ADDR)
              begin
                nxt_rd = sda_q_ff;
                // A foreign address is left alone until the next start
                nxt_state = (shift_ff[6:0] == OWN_ADDR) ? ST_ADDR_ACK : ST_IDLE; // RQ11
              end
              else if (state_ff == ST_PTR)
              begin
                nxt_ptr = rx_byte; // RQ11
                nxt_state = ST_PTR_ACK;
              end
              else
              begin
                wr_en = ce_i; // RQ11
                nxt_state = ST_WDATA_ACK;
              end
            end
          end
        end
        ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK:
        begin
          // Pull low across the ninth clock, release on its falling edge
          if (scl_fall && !drv_ff)
          begin
            nxt_drv = 1'b1;
            nxt_oe = 1'b1;
          end
          else if (scl_fall)
          begin
            nxt_drv = 1'b0;
            nxt_oe = 1'b0;
            nxt_cnt = CNT_ZERO;
            if (state_ff == ST_ADDR_ACK && rd_ff)
            begin
              nxt_tx = rd_data;
              nxt_oe = ~rd_data[7];
              nxt_state = ST_RDATA;
            end
            else if (state_ff == ST_ADDR_ACK)
            begin
              nxt_state = ST_PTR;
            end
            else
            begin
              // Pointer steps so a burst fills consecutive registers
              if (state_ff == ST_WDATA_ACK)
              begin
                nxt_ptr = ptr_ff + PTR_STEP;
              end
              nxt_state = ST_WDATA;
            end
          end
        end
        ST_RDATA:
        begin
          if (scl_rise)
          begin
            nxt_cnt = 4'(cnt_ff + CNT_ONE);
          end
          if (scl_fall && cnt_ff == BYTE_BITS)
          begin
            nxt_oe = 1'b0;
            nxt_drv = 1'b0;
            nxt_state = ST_RDATA_ACK;
          end
          else if (scl_fall)
          begin
            nxt_oe = ~tx_ff[3'(LAST_BIT - cnt_ff)];
          end
        end
        ST_RDATA_ACK:
        begin
          // Host acknowledge asks for the next register; no-ack ends the read
          if (scl_rise && !sda_q_ff)
          begin
            nxt_ptr = ptr_ff + PTR_STEP;
            nxt_drv = 1'b1;
          end
          else if (scl_rise)
          begin
            nxt_state = ST_IDLE;
          end
          else if (scl_fall && drv_ff)
          begin
            nxt_tx = rd_data;
            nxt_oe = ~rd_data[7];
            nxt_cnt = CNT_ZERO;
            nxt_drv = 1'b0;
            nxt_state = ST_RDATA;
          end
        end
        default:
        begin
          nxt_state = ST_IDLE;
          nxt_oe = 1'b0;
        end
      endcase
    end
  end

  // Sequencer registers; only pulls low, never drives high
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= CNT_ZERO;
      shift_ff <= '0;
      ptr_ff <= '0;
      tx_ff <= '0;
      drv_ff <= 1'b0;
      rd_ff <= 1'b0;
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
    end
    else if (ce_i)
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      ptr_ff <= nxt_ptr;
      tx_ff <= nxt_tx;
      drv_ff <= nxt_drv;
      rd_ff <= nxt_rd;
      sda_oe_o <= nxt_oe;
      sda_o <= 1'b0;
    end
  end

  ivd_reg_bank u_bank (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .wr_en_i(wr_en),
    .addr_i(ptr_ff),
    .wdata_i(rx_byte),
    .rdata_o(rd_data),
    .input_protect_enable_o(input_protect_enable_o),
    .input_regulation_select_o(input_regulation_select_o),
    .supply_detector_enable_o(supply_detector_enable_o),
    .detector_fall_level_o(detector_fall_level_o),
    .detector_rise_level_o(detector_rise_level_o),
    .second_overvoltage_level_o(second_overvoltage_level_o)
  );

  // Acknowledge, address match, write strobe and idle line checks
  sequence s_ack_open;
    ce_i && !start_cond && !stop_cond && scl_fall && !drv_ff
      && (state_ff == ST_ADDR_ACK || state_ff == ST_PTR_ACK || state_ff == ST_WDATA_ACK);
  endsequence

  sequence s_own_addr_done;
    ce_i && !start_cond && !stop_cond && state_ff == ST_ADDR && scl_rise
      && cnt_ff == LAST_BIT && shift_ff[6:0] == OWN_ADDR;
  endsequence

  AST_ACK_PULL: assert property (@(posedge clk_i) disable iff (srst_i) // RQ11
    s_ack_open |=> sda_oe_o && drv_ff)
    else $error("acknowledge not driven on ninth clock");

  AST_ADDR_MATCH: assert property (@(posedge clk_i) disable iff (srst_i) // RQ11
    s_own_addr_done |=> state_ff == ST_ADDR_ACK && !sda_oe_o)
    else $error("own address not accepted");

  AST_WRITE_PTR: assert property (@(posedge clk_i) disable iff (srst_i) // RQ11
    wr_en |-> state_ff == ST_WDATA && cnt_ff == LAST_BIT ##1 state_ff == ST_WDATA_ACK)
    else $error("write strobe outside a data byte");

  AST_IDLE_QUIET: assert property (@(posedge clk_i) disable iff (srst_i) // RQ11
    state_ff == ST_IDLE |-> !sda_oe_o)
    else $error("data line pulled while idle");

endmodule : ivd_config_top

`default_nettype wire

// ---- rtl/ivd_pkg.sv ----
/*
  Shared constants for the input voltage detect configuration block:
  register offsets, reset values, field positions and the serial
  target state encoding.
  Assumes nothing beyond a SystemVerilog compiler; imported by all
  design files of the block.
*/
package ivd_pkg;

  // Register offsets as seen by the serial host
  localparam logic [7:0] ADDR_PROT_CFG = 8'hD3;
  localparam logic [7:0] ADDR_RISE_LVL = 8'hD4;
  localparam logic [7:0] ADDR_OVP2_LVL = 8'hD5;

  // Register reset values
  localparam logic [7:0] RST_PROT_CFG = 8'h20;
  localparam logic [7:0] RST_RISE_LVL = 8'h03;
  localparam logic [7:0] RST_OVP2_LVL = 8'h3F;

  // Field positions and widths
  localparam int PROT_EN_BIT = 7;
  localparam int REG_SEL_BIT = 6;
  localparam int DET_EN_BIT = 5;
  localparam int LEVEL_W = 5;
  localparam int OVP2_W = 6;
  localparam int BYTE_W = 8;

  // Serial byte framing
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [7:0] PTR_STEP = 8'h01;

  // Target states, Gray coded along the usual path
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_PTR = 4'h2,
    ST_PTR_ACK = 4'h6,
    ST_WDATA = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA = 4'h4,
    ST_RDATA_ACK = 4'hC
  } ivd_state_t;

endpackage : ivd_pkg

// ---- rtl/ivd_reg_bank.sv ----
/*
  The three configuration registers of the input voltage detect block,
  with write decode, read mux and masking of unimplemented bits.
  Assumes a single clock, a synchronous active-high reset and a write
  strobe that already includes the clock enable.
*/
`timescale 1ns/1ps
`default_nettype none

module ivd_reg_bank
  import ivd_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic wr_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic input_protect_enable_o,
  output logic input_regulation_select_o,
  output logic supply_detector_enable_o,
  output logic [LEVEL_W-1:0] detector_fall_level_o,
  output logic [LEVEL_W-1:0] detector_rise_level_o,
  output logic [OVP2_W-1:0] second_overvoltage_level_o
);

  logic nxt_prot_en;
  logic nxt_reg_sel;
  logic nxt_det_en;
  logic [LEVEL_W-1:0] nxt_fall;
  logic [LEVEL_W-1:0] nxt_rise;
  logic [OVP2_W-1:0] nxt_ovp2;

  // Write decode; bits beyond each field are simply not stored
  always_comb
  begin
    nxt_prot_en = input_protect_enable_o;
    nxt_reg_sel = input_regulation_select_o;
    nxt_det_en = supply_detector_enable_o;
    nxt_fall = detector_fall_level_o;
    nxt_rise = detector_rise_level_o;
    nxt_ovp2 = second_overvoltage_level_o;
    if (wr_en_i && addr_i == ADDR_PROT_CFG)
    begin
      nxt_prot_en = wdata_i[PROT_EN_BIT]; // RQ1
      nxt_reg_sel = wdata_i[REG_SEL_BIT]; // RQ2
      nxt_det_en = wdata_i[DET_EN_BIT]; // RQ3
      nxt_fall = wdata_i[LEVEL_W-1:0]; // RQ4
    end
    else if (wr_en_i && addr_i == ADDR_RISE_LVL)
    begin
      nxt_rise = wdata_i[LEVEL_W-1:0]; // RQ5 RQ7
    end
    else if (wr_en_i && addr_i == ADDR_OVP2_LVL)
    begin
      nxt_ovp2 = wdata_i[OVP2_W-1:0]; // RQ10 RQ7
    end
  end

  // Field registers, loaded from the register reset values
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      input_protect_enable_o <= RST_PROT_CFG[PROT_EN_BIT]; // RQ8
      input_regulation_select_o <= RST_PROT_CFG[REG_SEL_BIT];
      supply_detector_enable_o <= RST_PROT_CFG[DET_EN_BIT]; // RQ3
      detector_fall_level_o <= RST_PROT_CFG[LEVEL_W-1:0];
      detector_rise_level_o <= RST_RISE_LVL[LEVEL_W-1:0];
      second_overvoltage_level_o <= RST_OVP2_LVL[OVP2_W-1:0]; // RQ9
    end
    else if (ce_i)
    begin
      input_protect_enable_o <= nxt_prot_en;
      input_regulation_select_o <= nxt_reg_sel;
      supply_detector_enable_o <= nxt_det_en;
      detector_fall_level_o <= nxt_fall;
      detector_rise_level_o <= nxt_rise;
      second_overvoltage_level_o <= nxt_ovp2;
    end
  end

  // Read mux; unmapped offsets and unimplemented bits read zero
  always_comb
  begin
    rdata_o = '0;
    if (addr_i == ADDR_PROT_CFG)
    begin
      rdata_o = {input_protect_enable_o, input_regulation_select_o,
                 supply_detector_enable_o, detector_fall_level_o};
    end
    else if (addr_i == ADDR_RISE_LVL)
    begin
      rdata_o = {{(BYTE_W-LEVEL_W){1'b0}}, detector_rise_level_o}; // RQ6
    end
    else if (addr_i == ADDR_OVP2_LVL)
    begin
      rdata_o = {{(BYTE_W-OVP2_W){1'b0}}, second_overvoltage_level_o}; // RQ6
    end
  end

  // Checks on write effects, unimplemented-bit reads and reset contents
  AST_PROT_WRITE: assert property (@(posedge clk_i) disable iff (srst_i) // RQ1
    wr_en_i && addr_i == ADDR_PROT_CFG |=> input_protect_enable_o == $past(wdata_i[PROT_EN_BIT]))
    else $error("protection enable did not take written bit");

  AST_REG_SELECT: assert property (@(posedge clk_i) disable iff (srst_i) // RQ2
    wr_en_i && addr_i == ADDR_PROT_CFG |=> input_regulation_select_o == $past(wdata_i[REG_SEL_BIT]))
    else $error("regulation select did not take written bit");

  AST_FALL_WRITE: assert property (@(posedge clk_i) disable iff (srst_i) // RQ4
    wr_en_i && addr_i == ADDR_PROT_CFG |=> detector_fall_level_o == $past(wdata_i[LEVEL_W-1:0]))
    else $error("falling level did not take written code");

  AST_RISE_WRITE: assert property (@(posedge clk_i) disable iff (srst_i) // RQ5
    wr_en_i && addr_i == ADDR_RISE_LVL |=> detector_rise_level_o == $past(wdata_i[LEVEL_W-1:0]))
    else $error("rising level did not take written code");

  AST_OVP2_WRITE: assert property (@(posedge clk_i) disable iff (srst_i) // RQ10
    wr_en_i && addr_i == ADDR_OVP2_LVL |=> second_overvoltage_level_o == $past(wdata_i[OVP2_W-1:0]))
    else $error("second overvoltage level did not take written code");

  AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (srst_i) // RQ6
    (addr_i == ADDR_RISE_LVL |-> rdata_o[7:5] == 3'h0)
    and (addr_i == ADDR_OVP2_LVL |-> rdata_o[7:6] == 2'h0))
    else $error("unimplemented bits read nonzero");

  AST_OTHERS_KEPT: assert property (@(posedge clk_i) disable iff (srst_i) // RQ7
    wr_en_i && addr_i != ADDR_PROT_CFG |=> $stable(input_protect_enable_o)
      && $stable(supply_detector_enable_o) && $stable(detector_fall_level_o))
    else $error("write to another offset disturbed the protection register");

  AST_RESET_VALUES: assert property (@(posedge clk_i) disable iff (srst_i) // RQ8
    $past(srst_i) |-> {input_protect_enable_o, input_regulation_select_o,
      supply_detector_enable_o, detector_fall_level_o} == RST_PROT_CFG
      && detector_rise_level_o == RST_RISE_LVL[LEVEL_W-1:0]
      && second_overvoltage_level_o == RST_OVP2_LVL[OVP2_W-1:0]) // RQ9
    else $error("register contents wrong after reset");

endmodule : ivd_reg_bank

`default_nettype wire

// ---- testbench/ivd_host_model.sv ----
/*
  Behavioural serial host for the configuration block: start, stop,
  byte transfer and register write and read sequences.
  Assumes the bench resolves the open-drain data line with a pull-up
  and feeds the resolved level back on sda_i.
*/
`timescale 1ns/1ps
`default_nettype none

module ivd_host_model
(
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // Six cycles a half bit keeps each level above the four-cycle minimum
  localparam int HALF = 6;

  // Both lines released while no frame runs
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Lines change just after a rising edge, always by the same delay
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  // Works from idle and as a repeated start with the clock low
  task automatic start_cond;
    tick(2);
    sda_o = 1'b1;
    tick(HALF);
    scl_o = 1'b1;
    tick(HALF);
    sda_o = 1'b0;
    tick(HALF);
    scl_o = 1'b0;
  endtask : start_cond

  task automatic stop_cond;
    tick(2);
    sda_o = 1'b0;
    tick(HALF);
    scl_o = 1'b1;
    tick(HALF);
    sda_o = 1'b1;
    tick(HALF);
  endtask : stop_cond

  // Data moves two cycles after the clock fall, so no false start or stop
  task automatic put_bit(input logic b, output logic r);
    tick(2);
    sda_o = b;
    tick(HALF);
    scl_o = 1'b1;
    tick(HALF);
    r = sda_i;
    scl_o = 1'b0;
  endtask : put_bit

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      put_bit(d[i], r);
    end
    put_bit(1'b1, r);
    ack = ~r;
  endtask : put_byte

  task automatic get_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      put_bit(1'b1, r);
      d[i] = r;
    end
    put_bit(~more, r);
  endtask : get_byte

  // Address, pointer, then n data bytes; one ack bit per byte sent
  task automatic write_seq(input logic [6:0] dev, input logic [7:0] ptr,
    input logic [7:0] d [0:2], input int n, output logic [4:0] acks);
    acks = 5'h00;
    start_cond();
    put_byte({dev, 1'b0}, acks[0]);
    put_byte(ptr, acks[1]);
    for (int i = 0; i < n; i++)
    begin
      put_byte(d[i], acks[i + 2]);
    end
    stop_cond();
  endtask : write_seq

  // Pointer set, repeated start, then n bytes; last one not acked
  task automatic read_seq(input logic [6:0] dev, input logic [7:0] ptr, input int n,
    output logic [7:0] q [0:2]);
    logic a;
    q = '{8'h00, 8'h00, 8'h00};
    start_cond();
    put_byte({dev, 1'b0}, a);
    put_byte(ptr, a);
    start_cond();
    put_byte({dev, 1'b1}, a);
    for (int i = 0; i < n; i++)
    begin
      get_byte(i < n - 1, q[i]);
    end
    stop_cond();
  endtask : read_seq

endmodule : ivd_host_model

`default_nettype wire

// ---- testbench/testbench.sv ----
/*
  Self-checking bench for the configuration block: reset values, burst
  writes of boundary and random bytes, read-back, wrong address and a
  second reset.
  Assumes the host model above and a pull-up on the data line.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import ivd_pkg::*;

  localparam logic [6:0] DEV = 7'h3A; // Arbitrary target address
  localparam int LIMIT = 60000;
  logic clk_i;
  logic srst_i;
  logic ce_i;
  wire logic scl;
  wire logic host_sda;
  wire logic sda_line;
  logic sda_o;
  logic sda_oe_o;
  logic prot_en;
  logic reg_sel;
  logic det_en;
  logic [LEVEL_W-1:0] fall_lvl;
  logic [LEVEL_W-1:0] rise_lvl;
  logic [OVP2_W-1:0] ovp2_lvl;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] lfsr;
  logic [7:0] exp_q [0:2];
  logic [7:0] wd [0:2];
  logic [7:0] got [0:2];
  logic [4:0] acks;

  // Open drain with pull-up: low whenever either side pulls
  assign sda_line = host_sda & ~(sda_oe_o & ~sda_o);

  ivd_config_top #(.DEV_ADDR(int'(DEV))) dut (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .scl_i(scl),
    .sda_i(sda_line),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .input_protect_enable_o(prot_en),
    .input_regulation_select_o(reg_sel),
    .supply_detector_enable_o(det_en),
    .detector_fall_level_o(fall_lvl),
    .detector_rise_level_o(rise_lvl),
    .second_overvoltage_level_o(ovp2_lvl)
  );

  ivd_host_model host (
    .clk_i(clk_i),
    .sda_i(sda_line),
    .scl_o(scl),
    .sda_o(host_sda)
  );

  // 25 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  function automatic logic [7:0] next_lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : next_lfsr

  // Only implemented bits keep what was written
  function automatic logic [7:0] reg_mask(input int idx);
    return (idx == 0) ? 8'hFF : (idx == 1) ? 8'h1F : 8'h3F;
  endfunction : reg_mask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  task automatic cmp_data(input logic [7:0] got_v, input logic [7:0] exp_v);
    checks++;
    if (got_v !== exp_v)
    begin
      failures++;
      $display("Error at %0t: data 0x%h, expected 0x%h", $time, got_v, exp_v);
    end
  endtask : cmp_data

  task automatic cmp_ack(input logic [4:0] got_v, input logic [4:0] exp_v);
    checks++;
    if (got_v !== exp_v)
    begin
      failures++;
      $display("Error at %0t: acks 0x%h, expected 0x%h", $time, got_v, exp_v);
    end
  endtask : cmp_ack

  // Burst read of all three registers plus the field ports
  task automatic check_all;
    host.read_seq(DEV, 8'hD3, 3, got);
    for (int i = 0; i < 3; i++)
    begin
      cmp_data(got[i], exp_q[i]);
    end
    cmp_data({prot_en, reg_sel, det_en, fall_lvl}, exp_q[0]);
    cmp_data({3'h0, rise_lvl}, exp_q[1]);
    cmp_data({2'h0, ovp2_lvl}, exp_q[2]);
  endtask : check_all

  task automatic do_reset;
    srst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    srst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    exp_q = '{8'h20, 8'h03, 8'h3F};
  endtask : do_reset

  // Hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      failures++;
      $display("Error at %0t: run did not finish in time", $time);
      final_report();
    end
  end

  initial
  begin
    srst_i = 1'b1;
    ce_i = 1'b1;
    lfsr = 8'h31;
    do_reset();
    check_all();
    // Boundary bytes first, then random ones, written back to back
    for (int k = 0; k < 10; k++)
    begin
      for (int i = 0; i < 3; i++)
      begin
        lfsr = next_lfsr(lfsr);
        wd[i] = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : lfsr;
        exp_q[i] = wd[i] & reg_mask(i);
      end
      host.write_seq(DEV, 8'hD3, wd, 3, acks);
      cmp_ack(acks, 5'h1F);
      check_all();
    end
    // Single byte to the last register leaves the others alone
    wd[0] = next_lfsr(lfsr);
    exp_q[2] = wd[0] & 8'h3F;
    host.write_seq(DEV, 8'hD5, wd, 1, acks);
    cmp_ack(acks, 5'h07);
    check_all();
    // Unmapped offset is acked, dropped and reads zero
    host.write_seq(DEV, 8'hD6, wd, 1, acks);
    cmp_ack(acks, 5'h07);
    host.read_seq(DEV, 8'hD6, 1, got);
    cmp_data(got[0], 8'h00);
    // Another target address must change nothing
    host.write_seq(DEV ^ 7'h01, 8'hD3, '{8'h5A, 8'hFF, 8'h00}, 3, acks);
    cmp_ack(acks, 5'h00);
    check_all();
    // Enable low freezes the block, so a whole frame goes unseen
    ce_i = 1'b0;
    host.write_seq(DEV, 8'hD3, '{8'h5A, 8'hFF, 8'h00}, 3, acks);
    ce_i = 1'b1;
    cmp_ack(acks, 5'h00);
    check_all();
    // Second reset in mid-run brings back the reset values
    do_reset();
    check_all();
    final_report();
  end

endmodule : testbench

`default_nettype wire
